// >>> lbp_far_model.sv
// Purpose: Far-side processor and DMA channel model
// Assumes: Same clock as the port
// Notes: Ends single-address DMA after a fixed delay
module lbp_far_model #(
  parameter int ACK_DELAY = 2
) (
  // Clock
  input wire logic ref_clk,
  // Bench control
  input wire logic otherMaster,
  // Port status
  input wire logic local_dma_cycle,
  input wire logic dualAddress,
  // Bus lines
  output logic bus_busy_grant_ack_n,
  output logic transfer_ack_in_n = 1'h1
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;
  assign bus_busy_grant_ack_n = !otherMaster;
  always @(posedge ref_clk)
  begin
    cnt <= (local_dma_cycle && !dualAddress) ? cnt + 1 : 0;
    transfer_ack_in_n <= #1 !(cnt == ACK_DELAY);
  end
endmodule // lbp_far_model

// >>> lbp_local_port.sv
// Purpose: Local processor bus port: arbitration, slave waits, local DMA
// Assumes: Inputs synchronous to ref_clk; core answers via coreReady
// Notes: Open-drain style outputs use enable low while driving
module lbp_local_port
  import lbp_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Configuration
  input wire logic busFlavour,
  // Arbitration
  input wire logic masterRequest,
  input wire logic bus_busy_grant_ack_n,
  output logic busOwned,
  output logic busBusyDrive_n,
  output logic busBusyOe_n,
  // Slave access
  input wire logic transfer_start_n,
  input wire logic bridge_window_select_n,
  input wire logic registerSelect_n,
  input wire logic burstCycle,
  input wire logic writeCycle,
  input wire logic [31:0] address,
  input wire logic [3:0] transfer_code,
  // Local DMA
  input wire logic dmaPending,
  input wire logic dma_acknowledge_n,
  input wire logic dmaDone_n,
  output logic dma_request_n,
  output logic local_dma_cycle,
  output logic dualAddress,
  output logic dmaFinished,
  // Termination pins
  input wire logic transfer_ack_in_n,
  input wire logic transfer_error_ack_in_n,
  input wire logic transfer_retry_in_n,
  output logic transfer_ack_n,
  output logic transferAckOe_n,
  output logic transfer_error_ack_n,
  output logic transferErrorOe_n,
  output logic transfer_retry_n,
  output logic transferRetryOe_n,
  // Core side
  input wire logic coreReady,
  input wire logic coreError,
  input wire logic coreRetry,
  output logic coreStart,
  output logic [1:0] coreKind
);
  lbp_wait_if wif ();
  lbp_wait_counter u_wait (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .w(wif)
  );

  function automatic logic isUnaligned(input logic [31:0] a);
    isUnaligned = a[LINE_LSB-1:0] != '0;
  endfunction

  lbp_state_e state, next_state;
  logic regSync, next_regSync;
  logic next_busOwned, next_drv, next_oe;
  logic next_dmaReq, next_dmaCycle, next_dual, next_fin;
  logic next_ackOut, next_ackOe, next_errOut, next_errOe;
  logic next_rty, next_rtyOe;
  logic next_start;
  logic [1:0] next_kind;
  logic slaveHit;
  logic [3:0] waits;

  // ----------------------------------------------------------------
  // Wait-state choice
  // ----------------------------------------------------------------
  assign slaveHit = !transfer_start_n
    && (!bridge_window_select_n || !registerSelect_n);

  always_comb
  begin
    waits = 4'h0;
    if (!registerSelect_n)
    begin
      // Sync depth differs with phase, so latency is not fixed
      waits = regSync ? 4'(REG_SYNC_MAX) : 4'(REG_SYNC_MIN);
    end
    else if (burstCycle && isUnaligned(address))
    begin
      if (busFlavour == FLAVOUR_A && writeCycle)
      begin
        waits = 4'(UNALIGNED_WAITS);
      end
      else if (busFlavour == FLAVOUR_B && !writeCycle)
      begin
        waits = 4'(UNALIGNED_WAITS);
      end
      else if (busFlavour == FLAVOUR_B)
      begin
        waits = 4'(UNALIGNED_WAITS);
      end
    end
  end

  // ----------------------------------------------------------------
  // Main sequencer
  // ----------------------------------------------------------------
  always_comb
  begin
    next_state = state;
    next_regSync = ~regSync;
    next_busOwned = busOwned;
    next_drv = busBusyDrive_n;
    next_oe = busBusyOe_n;
    next_dmaReq = !dmaPending;
    next_dmaCycle = local_dma_cycle;
    next_dual = dualAddress;
    next_fin = 1'b0;
    next_ackOut = 1'b1;
    next_ackOe = 1'b1;
    next_errOut = 1'b1;
    next_errOe = 1'b1;
    next_rty = 1'b1;
    next_rtyOe = 1'b1;
    next_start = 1'b0;
    next_kind = coreKind;
    wif.load = 1'b0;
    wif.count = waits;
    unique case (state)
      ST_IDLE:
      begin
        if (!dma_acknowledge_n && !transfer_start_n)
        begin
          // No address decode here; select only picks the mode
          next_dmaCycle = 1'b1;
          next_dual = !bridge_window_select_n;
          next_start = 1'b1;
          next_state = ST_DMA;
        end
        else if (slaveHit)
        begin
          next_kind = !registerSelect_n ? KIND_REG
            : (burstCycle ? KIND_BURST : KIND_SINGLE);
          wif.load = 1'b1;
          next_state = ST_WAIT;
        end
        else if (masterRequest)
        begin
          if (bus_busy_grant_ack_n)
          begin
            next_busOwned = 1'b1;
            next_drv = 1'b0;
            next_oe = 1'b0;
            next_state = ST_OWN;
          end
        end
      end
      ST_WAIT:
      begin
        if (wif.expired)
        begin
          next_start = 1'b1;
          next_state = ST_ACK;
        end
      end
      ST_ACK:
      begin
        if (coreReady || coreError || coreRetry)
        begin
          next_ackOut = !coreReady || coreError || coreRetry;
          next_ackOe = next_ackOut;
          next_errOut = !coreError;
          next_errOe = !coreError;
          next_rty = !(coreRetry && !coreError);
          next_rtyOe = next_rty;
          next_state = ST_DONE;
        end
      end
      ST_OWN:
      begin
        if (!masterRequest)
        begin
          next_busOwned = 1'b0;
          next_drv = 1'b1;
          next_oe = 1'b1;
          next_state = ST_IDLE;
        end
      end
      ST_DMA:
      begin
        // DMA-done is never looked at on flavour A
        if (busFlavour == FLAVOUR_B && !dmaDone_n)
        begin
          next_fin = 1'b1;
        end
        if (dualAddress)
        begin
          if (coreReady)
          begin
            // Only normal acknowledge in dual-address mode
            next_ackOut = 1'b0;
            next_ackOe = 1'b0;
            next_state = ST_DONE;
          end
        end
        else if (!transfer_ack_in_n || !transfer_error_ack_in_n
          || !transfer_retry_in_n)
        begin
          next_state = ST_DONE;
        end
      end
      ST_DONE:
      begin
        if (transfer_start_n)
        begin
          next_dmaCycle = 1'b0;
          next_dual = 1'b0;
          next_state = ST_IDLE;
        end
      end
      default:
      begin
        next_state = ST_IDLE;
      end
    endcase
  end
  // flavour A path above never reads dmaDone_n

  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      state <= ST_IDLE;
      regSync <= 1'b0;
      busOwned <= 1'b0;
      busBusyDrive_n <= 1'b1;
      busBusyOe_n <= 1'b1;
      dma_request_n <= 1'b1;
      local_dma_cycle <= 1'b0;
      dualAddress <= 1'b0;
      dmaFinished <= 1'b0;
      transfer_ack_n <= 1'b1;
      transferAckOe_n <= 1'b1;
      transfer_error_ack_n <= 1'b1;
      transferErrorOe_n <= 1'b1;
      transfer_retry_n <= 1'b1;
      transferRetryOe_n <= 1'b1;
      coreStart <= 1'b0;
      coreKind <= KIND_SINGLE;
    end
    else
    begin
      state <= next_state;
      regSync <= next_regSync;
      busOwned <= next_busOwned;
      busBusyDrive_n <= next_drv;
      busBusyOe_n <= next_oe;
      dma_request_n <= next_dmaReq;
      local_dma_cycle <= next_dmaCycle;
      dualAddress <= next_dual;
      dmaFinished <= next_fin;
      transfer_ack_n <= next_ackOut;
      transferAckOe_n <= next_ackOe;
      transfer_error_ack_n <= next_errOut;
      transferErrorOe_n <= next_errOe;
      transfer_retry_n <= next_rty;
      transferRetryOe_n <= next_rtyOe;
      coreStart <= next_start;
      coreKind <= next_kind;
    end
  end
endmodule // lbp_local_port

// >>> lbp_local_port_properties.sv
// Purpose: Port-level properties of the local bus port
// Assumes: One clock domain, synchronous active-low reset
// Notes: A slave take is a start strobe without DMA acknowledge
module lbp_local_port_properties
  import lbp_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Inputs
  input wire logic busFlavour,
  input wire logic bus_busy_grant_ack_n,
  input wire logic transfer_start_n,
  input wire logic registerSelect_n,
  input wire logic burstCycle,
  input wire logic writeCycle,
  input wire logic [31:0] address,
  input wire logic dmaPending,
  input wire logic dma_acknowledge_n,
  // Outputs
  input wire logic busOwned,
  input wire logic dma_request_n,
  input wire logic local_dma_cycle,
  input wire logic dualAddress,
  input wire logic dmaFinished,
  input wire logic transferAckOe_n,
  input wire logic transferErrorOe_n,
  input wire logic transferRetryOe_n,
  input wire logic coreStart
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  logic odd;
  assign odd = registerSelect_n && address[3:0] != 4'h0;
  property p_own;
    !busOwned && !bus_busy_grant_ack_n |=> !busOwned;
  endproperty
  a_own: assert property (p_own) else $error("bus taken while busy");
  property p_wa;
    $fell(transfer_start_n) && dma_acknowledge_n && !busFlavour &&
      burstCycle && writeCycle && odd |=> !coreStart[*2] ##1 coreStart;
  endproperty
  a_wa: assert property (p_wa) else $error("no wait on burst");
  property p_wb;
    $fell(transfer_start_n) && dma_acknowledge_n && busFlavour &&
      burstCycle && odd |=> !coreStart[*2] ##1 coreStart;
  endproperty
  a_wb: assert property (p_wb) else $error("no wait on burst");
  property p_reg;
    $fell(transfer_start_n) && dma_acknowledge_n && !registerSelect_n
      |=> !coreStart[*3] ##[1:2] coreStart;
  endproperty
  a_reg: assert property (p_reg) else $error("register wait bad");
  property p_req;
    1'h1 |=> dma_request_n == !$past(dmaPending);
  endproperty
  a_req: assert property (p_req) else $error("dma request wrong");
  property p_sack;
    local_dma_cycle && !dualAddress |-> transferAckOe_n;
  endproperty
  a_sack: assert property (p_sack) else $error("ack driven");
  property p_done;
    !busFlavour |-> !dmaFinished;
  endproperty
  a_done: assert property (p_done) else $error("done not ignored");
  property p_dual;
    dualAddress |-> transferErrorOe_n && transferRetryOe_n;
  endproperty
  a_dual: assert property (p_dual) else $error("dual error");
endmodule // lbp_local_port_properties
bind lbp_local_port lbp_local_port_properties props (.*);

// >>> lbp_local_port_tb_top.sv
// Purpose: Self-checking bench for the local bus port
// Assumes: Inputs change 1 ns after the rising edge
// Notes: Core echoes coreStart as coreReady a cycle later
module lbp_local_port_tb_top
  import lbp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'h0, reset_n = 1'h0, busFlavour = 1'h0;
  logic masterRequest = 1'h0, otherMaster = 1'h0, dmaCore = 1'h0;
  logic transfer_start_n = 1'h1, bridge_window_select_n = 1'h1;
  logic registerSelect_n = 1'h1, burstCycle = 1'h0, writeCycle = 1'h0;
  logic [31:0] address = 32'h0;
  logic [3:0] transfer_code = 4'h0;
  logic dmaPending = 1'h0, dma_acknowledge_n = 1'h1, dmaDone_n = 1'h1;
  logic transfer_error_ack_in_n = 1'h1, transfer_retry_in_n = 1'h1;
  logic coreError = 1'h0, coreRetry = 1'h0, coreReady = 1'h0;
  logic bus_busy_grant_ack_n, busOwned, busBusyDrive_n, busBusyOe_n;
  logic dma_request_n, local_dma_cycle, dualAddress, dmaFinished;
  logic transfer_ack_in_n, transfer_ack_n, transferAckOe_n;
  logic transfer_error_ack_n, transferErrorOe_n, coreStart;
  logic transfer_retry_n, transferRetryOe_n;
  logic [1:0] coreKind;
  int failures = 0, check_count = 0, n;
  lbp_local_port dut (.*);
  lbp_far_model far (.*);
  initial forever #20 ref_clk = !ref_clk;
  always @(posedge ref_clk)
    coreReady <= #1 coreStart | dmaCore;
  task automatic cyc(input int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic fl, bu, wr, rs, input logic [3:0] lo);
    int k;
    {busFlavour, burstCycle, writeCycle, registerSelect_n} = {fl, bu, wr, rs};
    bridge_window_select_n = !rs;
    address = {28'h0000100, lo};
    transfer_start_n = 1'h0;
    n = 0;
    do
    begin
      cyc(1);
      n++;
    end while (coreStart !== 1'h1 && n < 20);
    k = !rs ? KIND_REG : (bu ? KIND_BURST : KIND_SINGLE);
    chk(8'(coreKind), 8'(k));
    k = 0;
    while (transfer_ack_n !== 1'h0 && k < 8)
    begin
      cyc(1);
      k++;
    end
    chk(8'(k), 8'h02);
    chk(8'(transferAckOe_n), 8'h00);
    chk(8'({transfer_error_ack_n, transferErrorOe_n}), 8'h03);
    chk(8'({transfer_retry_n, transferRetryOe_n}), 8'h03);
    {transfer_start_n, bridge_window_select_n, registerSelect_n} = 3'h7;
    cyc(2);
  endtask
  task automatic dma(input logic fl, input logic dual);
    logic a, f, e;
    busFlavour = fl;
    dmaPending = 1'h1;
    cyc(2);
    chk(8'(dma_request_n), 8'h00);
    {dmaCore, dma_acknowledge_n, transfer_start_n} = {dual, 2'h0};
    {bridge_window_select_n, dmaDone_n} = {!dual, 1'h0};
    address = 32'hFFFF_FFF3;
    {a, f, e} = 3'h0;
    // Ack and done may last one cycle, so sample from the take edge on
    repeat (10)
    begin
      cyc(1);
      a |= !transferAckOe_n && !transfer_ack_n;
      f |= dmaFinished;
      e |= !transferErrorOe_n || !transferRetryOe_n;
    end
    chk({6'h0, local_dma_cycle, dualAddress}, {6'h0, 1'h1, dual});
    chk(8'(a), 8'(dual));
    chk(8'(f), 8'(fl));
    chk(8'(e), 8'h00);
    {dmaPending, dma_acknowledge_n, transfer_start_n, dmaCore} = 4'h6;
    {bridge_window_select_n, dmaDone_n} = 2'h3;
    cyc(3);
    chk(8'({dma_request_n, local_dma_cycle}), 8'h02);
  endtask
  task automatic t_arb;
    {otherMaster, masterRequest} = 2'h3;
    cyc(6);
    chk(8'({busOwned, busBusyDrive_n, busBusyOe_n}), 8'h03);
    otherMaster = 1'h0;
    cyc(4);
    chk(8'({busOwned, busBusyDrive_n, busBusyOe_n}), 8'h04);
    masterRequest = 1'h0;
    cyc(3);
    chk(8'({busOwned, busBusyDrive_n, busBusyOe_n}), 8'h03);
    $display("test arbitration done");
  endtask
  task automatic t_slave;
    acc(FLAVOUR_A, 1'h1, 1'h1, 1'h1, 4'h4);
    chk(8'(n), 8'h03);
    acc(FLAVOUR_A, 1'h1, 1'h1, 1'h1, 4'h0);
    chk(8'(n), 8'h02);
    acc(FLAVOUR_A, 1'h0, 1'h0, 1'h1, 4'h4);
    chk(8'(n), 8'h02);
    acc(FLAVOUR_B, 1'h1, 1'h0, 1'h1, 4'hC);
    chk(8'(n), 8'h03);
    acc(FLAVOUR_B, 1'h1, 1'h1, 1'h1, 4'hF);
    chk(8'(n), 8'h03);
    $display("test slave done");
  endtask
  task automatic t_reg;
    acc(FLAVOUR_B, 1'h0, 1'h0, 1'h0, 4'h0);
    chk(8'(n == 4 || n == 5), 8'h01);
    acc(FLAVOUR_A, 1'h0, 1'h1, 1'h0, 4'h0);
    chk(8'(n == 4 || n == 5), 8'h01);
    $display("test register done");
  endtask
  task automatic t_dma;
    dma(FLAVOUR_A, 1'h0);
    dma(FLAVOUR_B, 1'h1);
    dma(FLAVOUR_A, 1'h1);
    dma(FLAVOUR_B, 1'h0);
    $display("test dma done");
  endtask
  task automatic end_sim;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    cyc(4);
    reset_n = 1'h1;
    cyc(1);
    t_arb();
    t_slave();
    t_reg();
    t_dma();
    end_sim();
  end
  // Whole run needs about 130 cycles
  initial
  begin
    cyc(3000);
    failures++;
    end_sim();
  end
endmodule // lbp_local_port_tb_top

// >>> lbp_pkg.sv
// Purpose: Shared constants and types for the local bus port
// Assumes: One clock, ref_clk at 25 MHz
// Notes: Bus flavour A is the single-strobe flavour, B the split one
package lbp_pkg;
  // ----------------------------------------------------------------
  // Bus flavours, alignment and wait counts
  // ----------------------------------------------------------------
  localparam logic FLAVOUR_A = 1'b0;
  localparam logic FLAVOUR_B = 1'b1;
  localparam int LINE_BYTES = 16;
  localparam int LINE_LSB = 4;
  localparam int UNALIGNED_WAITS = 1;
  localparam int REG_SYNC_MIN = 2;
  localparam int REG_SYNC_MAX = 3;
  // ----------------------------------------------------------------
  // Slave access kinds
  // ----------------------------------------------------------------
  localparam logic [1:0] KIND_SINGLE = 2'h0;
  localparam logic [1:0] KIND_BURST = 2'h1;
  localparam logic [1:0] KIND_REG = 2'h2;
  // ----------------------------------------------------------------
  // Port states
  // ----------------------------------------------------------------
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_WAIT = 6'h02,
    ST_ACK = 6'h04,
    ST_OWN = 6'h08,
    ST_DMA = 6'h10,
    ST_DONE = 6'h20
  } lbp_state_e;
endpackage

// >>> lbp_wait_counter.sv
// Purpose: Wait-state down counter
// Assumes: Synchronous active-low reset
// Notes: Expired is high while the count is zero and load is low
module lbp_wait_counter
  import lbp_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Control
  lbp_wait_if.cnt w
);
  logic [3:0] count;
  logic [3:0] next_count;

  always_comb
  begin
    next_count = count;
    if (w.load)
    begin
      next_count = w.count;
    end
    else if (count != 4'h0)
    begin
      next_count = count - 4'h1;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      count <= 4'h0;
    end
    else
    begin
      count <= next_count;
    end
  end

  assign w.expired = (count == 4'h0) && !w.load;
endmodule // lbp_wait_counter

// >>> lbp_wait_if.sv
// Purpose: Carries wait-count requests between the port and its counter
// Assumes: Same clock as the port
// Notes: Load is a one-cycle pulse
interface lbp_wait_if;
  logic load;
  logic [3:0] count;
  logic expired;
  modport ctrl (output load, output count, input expired);
  modport cnt (input load, input count, output expired);
endinterface
